// ### hdl/cms_pkg.sv
// Purpose: Constants for the counter mode and scaler control block
// Assumes: 16-bit register port with a 3-bit word address
// Notes: Offsets, command codes and gate codes are local to this block
package cms_pkg;
    // Register addresses
    localparam logic [2:0] A_MASTER = 3'h0;
    localparam logic [2:0] A_CMD = 3'h1;
    localparam logic [2:0] A_MODE = 3'h2;
    localparam logic [2:0] A_LOAD = 3'h3;
    localparam logic [2:0] A_HOLD = 3'h4;
    localparam logic [2:0] A_DATA = 3'h5;
    localparam logic [2:0] A_STATUS = 3'h6;
    localparam logic [2:0] A_COUNT = 3'h7;
    // Master mode fields
    localparam int MM_AUTOSEQ_DIS = 14;
    localparam int MM_DECIMAL = 15;
    localparam logic [15:0] MASTER_RST = 16'h0000;
    // Counter mode fields
    localparam int CM_SPECIAL = 7;
    localparam int CM_RELOAD = 6;
    localparam int CM_REPEAT = 5;
    localparam int CM_GATE_LSB = 13;
    localparam int CM_SRC_LSB = 8;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [2:0] GC_NONE = 3'h0;
    localparam logic [2:0] GC_LEVEL = 3'h1;
    localparam logic [2:0] GC_EDGE = 3'h2;
    // Commands: low byte of a write to A_CMD
    localparam logic [7:0] CMD_ARM = 8'h01;
    localparam logic [7:0] CMD_DISARM = 8'h02;
    localparam logic [7:0] CMD_LOAD_CNT = 8'h03;
    localparam logic [7:0] CMD_SEQ_OFF = 8'h04;
    localparam logic [7:0] CMD_SEQ_ON = 8'h05;
    localparam logic [3:0] CMD_PTR_OP = 4'h1;
    // Data pointer targets
    localparam logic [1:0] PTR_MODE = 2'h0;
    localparam logic [1:0] PTR_LOAD = 2'h1;
    localparam logic [1:0] PTR_HOLD = 2'h2;
    // Scaler
    localparam int SCALER_STAGES = 4;
    localparam logic [3:0] BIN_LAST = 4'hF;
    localparam logic [3:0] DEC_LAST = 4'h9;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage

// ### hdl/cms_counter_ctl.sv
// Purpose: Mode decode, scaler and one 16-bit counter with its control registers
// Assumes: src_pin and gate_pin are asynchronous; gate active high, source active rising
// Notes: Special gate modes fall back to their plain counterparts
// How it works
// - Pointer auto-sequence disabled: pointer moves only on a pointer-load command.
// - Auto-sequence enabled: pointer advances after each data-port access.
// - Disable bit written via master register or set/clear commands.
// - Binary scaler: each frequency is one sixteenth of the previous.
// - Decimal scaler: neighbouring frequencies differ by a factor of ten.
// - Plain modes count to terminal count once, then disarm.
// - Alternating reload without repetition disarms after the second terminal count.
// - Repetition set: counter never disarms itself.
// - Gate field zero: gate input never inhibits counting.
// - Level gating: count only while gate is high.
// - Edge gating, single reload: start on gate edge, stop at next terminal count.
// - Edge gating, alternating reload: stop at second terminal count.
// - Single reload source: reload from Load at every terminal count.
// - Alternating reload: sources swap between Load and Hold each terminal count.
// - Terminal count is the interval the counter would have held zero.
// - Mode chosen by gate field plus special, reload and repetition bits.
// - Disarming modes count only after the host arms the counter.
// - A counter in terminal count always counts, ignoring arming and gating.
`timescale 1ns/100ps
module cms_counter_ctl (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Counter pins
    input wire logic src_pin,
    input wire logic gate_pin,
    output logic terminal_count,
    // Scaler outputs
    output logic [4:0] scaler_freq
);
    function automatic logic [1:0] ptr_next(input logic [1:0] p);
        ptr_next = (p == cms_pkg::PTR_HOLD) ? cms_pkg::PTR_MODE : p + 2'h1;
    endfunction

    logic [15:0] master_q, mode_q, load_q, hold_q, count_q, rdata_q;
    logic [1:0] ptr_q;
    logic armed_q, tc_q, run_q, alt_q, tc_cnt_q, stop_pend_q;
    logic [2:0] src_sync_q, gate_sync_q;
    logic [3:0] dig_q [cms_pkg::SCALER_STAGES];
    logic [4:0] f_en;

    // Decode
    wire autoseq_dis = master_q[cms_pkg::MM_AUTOSEQ_DIS];
    wire dec_sel = master_q[cms_pkg::MM_DECIMAL];
    wire sg = mode_q[cms_pkg::CM_SPECIAL];
    wire rs = mode_q[cms_pkg::CM_RELOAD];
    wire rep = mode_q[cms_pkg::CM_REPEAT];
    wire [2:0] gc = mode_q[cms_pkg::CM_GATE_LSB +: 3];
    wire [3:0] src_sel = mode_q[cms_pkg::CM_SRC_LSB +: 4];
    wire data_acc = (wr || rd) && addr == cms_pkg::A_DATA;
    wire cmd_wr = wr && addr == cms_pkg::A_CMD;
    wire cmd_arm = cmd_wr && wdata[7:0] == cms_pkg::CMD_ARM;
    wire cmd_disarm = cmd_wr && wdata[7:0] == cms_pkg::CMD_DISARM;
    wire cmd_load = cmd_wr && wdata[7:0] == cms_pkg::CMD_LOAD_CNT;
    wire cmd_seq_off = cmd_wr && wdata[7:0] == cms_pkg::CMD_SEQ_OFF;
    wire cmd_seq_on = cmd_wr && wdata[7:0] == cms_pkg::CMD_SEQ_ON;
    wire cmd_ptr = cmd_wr && wdata[7:4] == cms_pkg::CMD_PTR_OP && wdata[1:0] != 2'h3;
    wire wr_data = wr && addr == cms_pkg::A_DATA;
    wire wr_mode = (wr && addr == cms_pkg::A_MODE) || (wr_data && ptr_q == cms_pkg::PTR_MODE);
    wire wr_load = (wr && addr == cms_pkg::A_LOAD) || (wr_data && ptr_q == cms_pkg::PTR_LOAD);
    wire wr_hold = (wr && addr == cms_pkg::A_HOLD) || (wr_data && ptr_q == cms_pkg::PTR_HOLD);
    wire wr_master = wr && addr == cms_pkg::A_MASTER;

    // Pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge mclk) begin
        if (srst) begin
            src_sync_q <= 3'h0;
            gate_sync_q <= 3'h0;
        end else begin
            src_sync_q <= {src_sync_q[1:0], src_pin};
            gate_sync_q <= {gate_sync_q[1:0], gate_pin};
        end
    end
    wire src_rise = src_sync_q[1] && !src_sync_q[2];
    wire gate_lvl = gate_sync_q[1];
    wire gate_rise = gate_sync_q[1] && !gate_sync_q[2];

    // Frequency scaler: F1 is mclk, each later stage one digit wrap of the previous
    wire [3:0] dig_last = dec_sel ? cms_pkg::DEC_LAST : cms_pkg::BIN_LAST;
    assign f_en[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 0; gi < cms_pkg::SCALER_STAGES; gi++) begin : g_scl
            assign f_en[gi + 1] = f_en[gi] && dig_q[gi] >= dig_last;
            always_ff @(posedge mclk) begin
                if (srst) begin
                    dig_q[gi] <= 4'h0;
                end else if (f_en[gi]) begin
                    // Reaching past the limit after a switch to decimal also wraps
                    dig_q[gi] <= (dig_q[gi] >= dig_last) ? 4'h0 : dig_q[gi] + 4'h1;
                end
            end
        end
    endgenerate
    assign scaler_freq = f_en;

    // Source and gate qualification
    wire [7:0] src_vec = {2'b00, f_en, src_rise};
    wire src_evt = !src_sel[3] && src_vec[src_sel[2:0]];
    wire gate_ok = (gc == cms_pkg::GC_LEVEL) ? gate_lvl :
                   (gc == cms_pkg::GC_EDGE) ? run_q : 1'b1;
    wire step = src_evt && (tc_q || (armed_q && gate_ok));
    wire reach_tc = step && !tc_q && count_q == cms_pkg::COUNT_ONE;
    wire leave_tc = step && tc_q;
    // Stop after this TC: single reload stops on first, alternating on second
    wire stop_here = !rs || tc_cnt_q;
    wire [15:0] reload_val = (rs && alt_q) ? hold_q : load_q;

    // Counter
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_q <= 16'h0000;
            tc_q <= 1'b0;
            alt_q <= 1'b0;
        end else if (cmd_load) begin
            count_q <= load_q;
            tc_q <= 1'b0;
            alt_q <= 1'b0;
        end else if (reach_tc) begin
            count_q <= reload_val;
            tc_q <= 1'b1;
            alt_q <= rs && !alt_q;
        end else if (step) begin
            count_q <= count_q - 16'h0001;
            tc_q <= 1'b0;
        end
    end

    // Arming, edge run and terminal count bookkeeping
    always_ff @(posedge mclk) begin
        if (srst) begin
            armed_q <= 1'b0;
            run_q <= 1'b0;
            tc_cnt_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end else begin
            if (cmd_arm) begin
                armed_q <= 1'b1;
                tc_cnt_q <= 1'b0;
            end else if (cmd_disarm) begin
                armed_q <= 1'b0;
            end else if (leave_tc && stop_pend_q && !rep) begin
                armed_q <= 1'b0;
            end
            if (reach_tc) begin
                stop_pend_q <= stop_here;
                tc_cnt_q <= !stop_here;
            end else if (leave_tc) begin
                stop_pend_q <= 1'b0;
            end
            if (gc != cms_pkg::GC_EDGE || cmd_disarm) begin
                run_q <= 1'b0;
            end else if (leave_tc && stop_pend_q) begin
                run_q <= 1'b0;
            end else if (gate_rise && armed_q) begin
                run_q <= 1'b1;
            end
        end
    end

    // Registers and data pointer
    always_ff @(posedge mclk) begin
        if (srst) begin
            master_q <= cms_pkg::MASTER_RST;
            mode_q <= cms_pkg::MODE_RST;
            load_q <= 16'h0000;
            hold_q <= 16'h0000;
            ptr_q <= cms_pkg::PTR_MODE;
        end else begin
            if (wr_master) begin
                master_q <= wdata;
            end else if (cmd_seq_off) begin
                master_q[cms_pkg::MM_AUTOSEQ_DIS] <= 1'b1;
            end else if (cmd_seq_on) begin
                master_q[cms_pkg::MM_AUTOSEQ_DIS] <= 1'b0;
            end
            if (wr_mode) begin
                mode_q <= wdata;
            end
            if (wr_load) begin
                load_q <= wdata;
            end
            if (wr_hold) begin
                hold_q <= wdata;
            end
            if (cmd_ptr) begin
                ptr_q <= wdata[1:0];
            end else if (data_acc && !autoseq_dis) begin
                ptr_q <= ptr_next(ptr_q);
            end
        end
    end

    // Read mux; answer stands one cycle after the strobe
    wire [15:0] data_rd = (ptr_q == cms_pkg::PTR_MODE) ? mode_q :
                          (ptr_q == cms_pkg::PTR_LOAD) ? load_q : hold_q;
    wire [15:0] status = {9'h000, ptr_q, stop_pend_q, tc_cnt_q, run_q, tc_q, armed_q};
    wire [15:0] rd_mux = (addr == cms_pkg::A_MASTER) ? master_q :
                         (addr == cms_pkg::A_MODE) ? mode_q :
                         (addr == cms_pkg::A_LOAD) ? load_q :
                         (addr == cms_pkg::A_HOLD) ? hold_q :
                         (addr == cms_pkg::A_DATA) ? data_rd :
                         (addr == cms_pkg::A_STATUS) ? status :
                         (addr == cms_pkg::A_COUNT) ? count_q : 16'h0000;
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rd ? rd_mux : 16'h0000;
        end
    end
    assign rdata = rdata_q;
    assign terminal_count = tc_q;

    // Checks
    property p_seq_hold;
        @(posedge mclk) disable iff (srst)
        (data_acc && autoseq_dis && !cmd_wr) |=> $stable(ptr_q);
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("pointer moved while frozen");

    property p_seq_adv;
        @(posedge mclk) disable iff (srst)
        (data_acc && !autoseq_dis && ptr_q == cms_pkg::PTR_MODE) |=> ptr_q == cms_pkg::PTR_LOAD;
    endproperty
    a_seq_adv: assert property (p_seq_adv) else $error("pointer did not advance");

    property p_seq_set;
        @(posedge mclk) disable iff (srst)
        cmd_seq_off |=> autoseq_dis && dec_sel == $past(dec_sel);
    endproperty
    a_seq_set: assert property (p_seq_set) else $error("set command failed");

    property p_scl_bin;
        @(posedge mclk) disable iff (srst)
        (f_en[1] && !dec_sel && !wr_master) |-> ##16 (f_en[1] || dec_sel);
    endproperty
    a_scl_bin: assert property (p_scl_bin) else $error("binary scaler ratio wrong");

    property p_scl_dec;
        @(posedge mclk) disable iff (srst)
        (f_en[1] && dec_sel && !wr_master) ##1 (!f_en[1])[*8] ##1 !f_en[1] |->
            ##1 (f_en[1] || !dec_sel);
    endproperty
    a_scl_dec: assert property (p_scl_dec) else $error("decimal scaler ratio wrong");

    sequence s_leave_last;
        leave_tc && stop_pend_q && !rep && !cmd_arm;
    endsequence
    property p_disarm;
        @(posedge mclk) disable iff (srst)
        s_leave_last |=> !armed_q;
    endproperty
    a_disarm: assert property (p_disarm) else $error("counter failed to disarm");

    property p_keep_first;
        @(posedge mclk) disable iff (srst)
        (leave_tc && !stop_pend_q && armed_q && !cmd_disarm) |=> armed_q;
    endproperty
    a_keep_first: assert property (p_keep_first) else $error("disarmed too early");

    property p_level;
        @(posedge mclk) disable iff (srst)
        (gc == cms_pkg::GC_LEVEL && !gate_lvl && !tc_q && !wr && !cmd_load) |=> $stable(count_q);
    endproperty
    a_level: assert property (p_level) else $error("counted with gate low");

    property p_reload;
        @(posedge mclk) disable iff (srst)
        (reach_tc && !rs && !cmd_load) |=> tc_q && count_q == $past(load_q);
    endproperty
    a_reload: assert property (p_reload) else $error("reload from Load failed");

    property p_alt;
        @(posedge mclk) disable iff (srst)
        (reach_tc && rs && alt_q && !cmd_load) |=> count_q == $past(hold_q) && !alt_q;
    endproperty
    a_alt: assert property (p_alt) else $error("reload from Hold failed");

    property p_tc_counts;
        @(posedge mclk) disable iff (srst)
        (tc_q && src_evt && !cmd_load) |=> !tc_q;
    endproperty
    a_tc_counts: assert property (p_tc_counts) else $error("terminal count ignored edge");

    property p_dec;
        @(posedge mclk) disable iff (srst)
        (step && !reach_tc && !cmd_load) |=> count_q == $past(count_q) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
endmodule

// ### bench/cms_host_model.sv
// Purpose: Host processor model on the register port
// Assumes: One strobe per access, changed just after the rising edge
// Notes: Idle write data shows the inverse of the last word, never a stale copy
`timescale 1ns/100ps
module cms_host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output logic [2:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Idle cycle after each access keeps one driver write per time step
    task automatic put(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic get(input logic [2:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask
endmodule

// ### bench/counter_mode_and_scaler_control_test.sv
// Purpose: Self-checking bench for the counter mode and scaler control block
// Assumes: Read answers are queued by the driver and matched by a monitor
// Notes: Pin events are counted on the falling edge to avoid edge races
`timescale 1ns/100ps
module counter_mode_and_scaler_control_test;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic src_pin = 1'b0;
    logic gate_pin = 1'b0;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic terminal_count;
    logic [4:0] scaler_freq;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    logic rd_seen = 1'b0;
    logic tc_prev = 1'b0;
    logic [15:0] v0, v1, v2;
    int n_mismatch = 0;
    int cmp_count = 0;
    int tc_edges = 0;
    int f_cnt[3] = '{0, 0, 0};

    always #12.5 mclk = ~mclk;

    cms_counter_ctl u_cms_counter_ctl (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .src_pin(src_pin), .gate_pin(gate_pin),
        .terminal_count(terminal_count), .scaler_freq(scaler_freq));
    cms_host_model u_cms_host_model (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    task automatic check16(input logic [15:0] e, input logic [15:0] m, input logic [15:0] g);
        cmp_count++;
        if ((g & m) !== (e & m)) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
        end
    endtask
    task automatic check_int(input int e, input int g);
        cmp_count++;
        if (e != g) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) check16(16'h0000, 16'hFFFF, 16'hFFFF);
            else check16(exp_q.pop_front(), msk_q.pop_front(), rdata);
        end
        rd_seen = (rd === 1'b1);
    end
    always @(negedge mclk) begin
        if (terminal_count === 1'b1 && tc_prev === 1'b0) tc_edges++;
        tc_prev = (terminal_count === 1'b1);
        if (scaler_freq[0] === 1'b1) f_cnt[0]++;
        if (scaler_freq[1] === 1'b1) f_cnt[1]++;
        if (scaler_freq[2] === 1'b1) f_cnt[2]++;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        u_cms_host_model.put(a, d);
    endtask
    task automatic cmd(input logic [7:0] c);
        u_cms_host_model.put(cms_pkg::A_CMD, {8'h00, c});
    endtask
    task automatic expect_rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        u_cms_host_model.get(a);
    endtask
    // Two cycles high, two low: clears the pin synchroniser
    task automatic pulse_src(input int n);
        repeat (n) begin
            src_pin <= 1'b1;
            idle(2);
            src_pin <= 1'b0;
            idle(2);
        end
    endtask
    // Gate: 0 low, 1 high, 2 one rising edge after arming
    task automatic run_mode(input logic [15:0] m, input int g, input logic arm, input int ntc);
        wr_reg(cms_pkg::A_MODE, m);
        wr_reg(cms_pkg::A_LOAD, 16'h0002);
        wr_reg(cms_pkg::A_HOLD, 16'h0003);
        cmd(cms_pkg::CMD_DISARM);
        cmd(cms_pkg::CMD_LOAD_CNT);
        gate_pin <= (g == 1);
        if (arm) cmd(cms_pkg::CMD_ARM);
        idle(4);
        if (g == 2) begin
            gate_pin <= 1'b1;
            idle(4);
            gate_pin <= 1'b0;
            idle(4);
        end
        tc_edges = 0;
        pulse_src(12);
        idle(8);
        check_int(ntc, tc_edges);
        expect_rd(cms_pkg::A_STATUS, {15'h0000, arm & m[5]}, 16'h0001);
        $display("mode %h test done", m);
    endtask
    // Window is a whole number of periods, so phase does not matter
    task automatic scaler_run(input logic [15:0] mm, input int e2, input int e3);
        int s0;
        int s1;
        int s2;
        wr_reg(cms_pkg::A_MASTER, mm);
        idle(300);
        s0 = f_cnt[0];
        s1 = f_cnt[1];
        s2 = f_cnt[2];
        // Window covers whole periods of the first three stages in both modes
        idle(6400);
        check_int(6400, f_cnt[0] - s0);
        check_int(e2, f_cnt[1] - s1);
        check_int(e3, f_cnt[2] - s2);
        $display("scaler %h test done", mm);
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'hA369));
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        expect_rd(cms_pkg::A_MASTER, cms_pkg::MASTER_RST, 16'hFFFF);
        expect_rd(cms_pkg::A_MODE, cms_pkg::MODE_RST, 16'hFFFF);
        expect_rd(cms_pkg::A_STATUS, 16'h0000, 16'h007F);
        $display("reset test done");
        v0 = 16'($urandom);
        v1 = 16'($urandom);
        v2 = 16'($urandom);
        cmd({cms_pkg::CMD_PTR_OP, 2'h0, cms_pkg::PTR_MODE});
        wr_reg(cms_pkg::A_DATA, v0);
        wr_reg(cms_pkg::A_DATA, v1);
        wr_reg(cms_pkg::A_DATA, v2);
        expect_rd(cms_pkg::A_MODE, v0, 16'hFFFF);
        expect_rd(cms_pkg::A_LOAD, v1, 16'hFFFF);
        expect_rd(cms_pkg::A_HOLD, v2, 16'hFFFF);
        cmd(cms_pkg::CMD_SEQ_OFF);
        expect_rd(cms_pkg::A_MASTER, 16'h4000, 16'hFFFF);
        cmd({cms_pkg::CMD_PTR_OP, 2'h0, cms_pkg::PTR_LOAD});
        wr_reg(cms_pkg::A_DATA, v2);
        wr_reg(cms_pkg::A_DATA, v0);
        expect_rd(cms_pkg::A_LOAD, v0, 16'hFFFF);
        expect_rd(cms_pkg::A_HOLD, v2, 16'hFFFF);
        expect_rd(cms_pkg::A_STATUS, 16'h0020, 16'h0060);
        cmd(cms_pkg::CMD_SEQ_ON);
        expect_rd(cms_pkg::A_MASTER, 16'h0000, 16'h4000);
        wr_reg(cms_pkg::A_DATA, v1);
        expect_rd(cms_pkg::A_STATUS, 16'h0040, 16'h0060);
        wr_reg(cms_pkg::A_MASTER, 16'h4000);
        expect_rd(cms_pkg::A_MASTER, 16'h4000, 16'hFFFF);
        $display("pointer test done");
        scaler_run(16'h0000, 400, 25);
        scaler_run(16'h8000, 640, 64);
        run_mode(16'h0000, 0, 1'b1, 1);
        run_mode(16'h0000, 0, 1'b0, 0);
        run_mode(16'h0040, 0, 1'b1, 2);
        run_mode(16'h0020, 0, 1'b1, 6);
        run_mode(16'h0060, 0, 1'b1, 5);
        run_mode(16'h2020, 0, 1'b1, 0);
        run_mode(16'h2020, 1, 1'b1, 6);
        run_mode(16'h4020, 2, 1'b1, 1);
        run_mode(16'h4060, 2, 1'b1, 2);
        wr_reg(cms_pkg::A_MODE, 16'h0020);
        wr_reg(cms_pkg::A_LOAD, 16'h0005);
        cmd(cms_pkg::CMD_LOAD_CNT);
        expect_rd(cms_pkg::A_COUNT, 16'h0005, 16'hFFFF);
        cmd(cms_pkg::CMD_ARM);
        pulse_src(3);
        idle(6);
        expect_rd(cms_pkg::A_COUNT, 16'h0002, 16'hFFFF);
        // Source code 8 selects nothing, so pin edges must not count
        wr_reg(cms_pkg::A_MODE, 16'h0820);
        pulse_src(2);
        idle(6);
        expect_rd(cms_pkg::A_COUNT, 16'h0002, 16'hFFFF);
        $display("count step test done");
        idle(4);
        if (exp_q.size() != 0) n_mismatch++;
        print_verdict;
    end
endmodule
